// *** src/lfam_mapper.sv ***
// Purpose: map two channels of samples onto eight serial lane octet streams
// Assumes: one octet per lane per sys_clk, frame clock derived internally
// Notes: encoding, scrambling and lane alignment happen downstream
//
// Overview of operation
// - 14-bit bypass sends one sample per lane per frame as bits 13:6 then 5:0 and two zeros.
// - 14-bit bypass puts channel samples zero to three on lanes zero to three of that channel.
// - 12-bit bypass packs five 12-bit samples per lane msb first and ends the frame with four zeros.
// - 12-bit bypass gives lane k of a channel samples 5k to 5k+4 of the twenty-sample frame.
// - complex decimation carries four converters, the I and Q streams of both channels.
// - divide-by-4 and -6 accept 8411, 8422 at 20X and 4421, 4442 at 40X with their codes.
// - divide-by-8 to -20 accept 4421 at 20X code 1 and 2441 at 40X code 2, other codes zero.
// - divide-by-24 and -32 accept only 2441 at 40X with first code 1 or 2 respectively.
// - at divide-by-4 and -6 the lane count dictates the serial multiplier, 20X for eight lanes, 40X for four.
// - 12-bit bypass drops the two lsbs of each 14-bit sample before packing.
// - F, L, M and S are octets, lanes, converters and samples per frame, agreed by both ends.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// frame fifo: registered full and empty, ready to the source is a flop
module lfam_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic ready;
  } lfam_fifo_st_t;

  lfam_fifo_st_t st;
  lfam_fifo_st_t next_st;
  logic push;
  logic pop;

  assign in_ready = st.ready;
  assign out_valid = (st.count != '0);
  assign out_data = st.mem[st.rd_ptr];

  // pointer wrap handles depths that are not a power of two
  always_comb begin
    next_st = st;
    push = in_valid && st.ready;
    pop = out_ready && (st.count != '0);
    if (push) begin
      next_st.mem[st.wr_ptr] = in_data;
      next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
    next_st.ready = (next_st.count != DEPTH_C);
  end

  // registered state
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st <= '0;
      st.ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// top: register port, format decode, frame sequencer and lane packer
module lfam_mapper #(
  parameter int FIFO_DEPTH = lfam_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic in_valid,
  output logic in_ready,
  input wire lfam_pkg::lfam_frame_t in_frame,
  input wire logic sync_n,
  output lfam_pkg::lfam_lanes_t lanes,
  output logic [7:0] lane_enable,
  output logic frame_start,
  output logic link_up
);

  typedef struct packed {
    logic [13:0] cfg;
    logic reject;
    logic up;
    logic sending;
    logic [2:0] octet;
    logic [3:0][63:0] a_sh;
    logic [3:0][63:0] b_sh;
    logic [7:0] lane_en;
    logic start;
    logic [31:0] frames;
    logic [31:0] underruns;
    logic [31:0] rdata;
  } lfam_st_t;

  lfam_st_t st;
  lfam_st_t next_st;
  lfam_pkg::lfam_frame_t head;
  logic head_valid;
  logic pop;
  lfam_pkg::lfam_fmt_t fmt;
  logic [3:0] f_len;
  logic [3:0] m_cnt;
  logic [3:0] l_cnt;

  //////////////////////////////////////////////////////////////////////////////
  // format decode from codes, multiplier and decimation
  function automatic lfam_pkg::lfam_fmt_t decode(input logic [13:0] cfg);
    logic [1:0] c0;
    logic [1:0] c1;
    logic [1:0] c2;
    logic [1:0] mult;
    logic [5:0] dec;
    lfam_pkg::lfam_fmt_t f;
    c0 = cfg[lfam_pkg::CFG_CODE_FIRST_LSB +: 2];
    c1 = cfg[lfam_pkg::CFG_CODE_SECOND_LSB +: 2];
    c2 = cfg[lfam_pkg::CFG_CODE_THIRD_LSB +: 2];
    mult = cfg[lfam_pkg::CFG_MULT_LSB +: 2];
    dec = cfg[lfam_pkg::CFG_DECIM_LSB +: 6];
    f = lfam_pkg::LFAM_FMT_NONE;
    case (dec)
      lfam_pkg::DECIM_BYPASS: begin
        if ({c0, c1, c2} == 6'h30 && mult == lfam_pkg::MULT_16X) begin
          f = lfam_pkg::LFAM_FMT_B12;
        end else if ({c0, c1, c2} == 6'h10 && mult == lfam_pkg::MULT_20X) begin
          f = lfam_pkg::LFAM_FMT_B14;
        end
      end
      6'h04, 6'h06: begin
        // eight lanes need 20X, four lanes need 40X
        if ({c0, c1, c2} == 6'h14 && mult == lfam_pkg::MULT_20X) begin
          f = lfam_pkg::LFAM_FMT_C8411;
        end else if ({c0, c1, c2} == 6'h10 && mult == lfam_pkg::MULT_20X) begin
          f = lfam_pkg::LFAM_FMT_C8422;
        end else if ({c0, c1, c2} == 6'h01 && mult == lfam_pkg::MULT_40X) begin
          f = lfam_pkg::LFAM_FMT_C4421W;
        end else if ({c0, c1, c2} == 6'h20 && mult == lfam_pkg::MULT_40X) begin
          f = lfam_pkg::LFAM_FMT_C4442;
        end
      end
      6'h08, 6'h09, 6'h0a, 6'h0c, 6'h10, 6'h12, 6'h14: begin
        if ({c0, c1, c2} == 6'h10 && mult == lfam_pkg::MULT_20X) begin
          f = lfam_pkg::LFAM_FMT_C4421N;
        end else if ({c0, c1, c2} == 6'h20 && mult == lfam_pkg::MULT_40X) begin
          f = lfam_pkg::LFAM_FMT_C2441;
        end
      end
      6'h18: begin
        if ({c0, c1, c2} == 6'h10 && mult == lfam_pkg::MULT_40X) begin
          f = lfam_pkg::LFAM_FMT_C2441;
        end
      end
      6'h20: begin
        if ({c0, c1, c2} == 6'h20 && mult == lfam_pkg::MULT_40X) begin
          f = lfam_pkg::LFAM_FMT_C2441;
        end
      end
      default: f = lfam_pkg::LFAM_FMT_NONE;
    endcase
    return f;
  endfunction

  // octets per frame, F
  function automatic logic [3:0] frame_octets(input lfam_pkg::lfam_fmt_t f);
    case (f)
      lfam_pkg::LFAM_FMT_B12: frame_octets = 4'h8;
      lfam_pkg::LFAM_FMT_C8411: frame_octets = 4'h1;
      lfam_pkg::LFAM_FMT_C4442, lfam_pkg::LFAM_FMT_C2441: frame_octets = 4'h4;
      lfam_pkg::LFAM_FMT_NONE: frame_octets = 4'h0;
      default: frame_octets = 4'h2;
    endcase
  endfunction

  // active lanes per channel as a mask, lane zero in bit 0
  function automatic logic [3:0] lane_mask(input lfam_pkg::lfam_fmt_t f);
    case (f)
      lfam_pkg::LFAM_FMT_B14, lfam_pkg::LFAM_FMT_B12,
      lfam_pkg::LFAM_FMT_C8411, lfam_pkg::LFAM_FMT_C8422: lane_mask = 4'hf;
      lfam_pkg::LFAM_FMT_C4421N: lane_mask = 4'h3;
      lfam_pkg::LFAM_FMT_C4421W, lfam_pkg::LFAM_FMT_C4442: lane_mask = 4'h6;
      lfam_pkg::LFAM_FMT_C2441: lane_mask = 4'h2;
      default: lane_mask = 4'h0;
    endcase
  endfunction

  // one lane's frame image, first octet in the top byte
  function automatic logic [63:0] build_lane(
    input lfam_pkg::lfam_fmt_t f,
    input logic [lfam_pkg::SAMPLES-1:0][15:0] s,
    input int lane
  );
    logic [63:0] img;
    logic [59:0] packed12;
    img = '0;
    packed12 = '0;
    case (f)
      lfam_pkg::LFAM_FMT_B14: begin
        img[63:48] = {s[lane][13:6], s[lane][5:0], 2'b00};
      end
      lfam_pkg::LFAM_FMT_B12: begin
        // drop two lsbs, pack five samples msb first
        for (int i = 0; i < 5; i++) begin
          packed12[59-12*i -: 12] = s[5*lane+i][13:2];
        end
        img = {packed12, 4'h0};
      end
      lfam_pkg::LFAM_FMT_C8411: begin
        // I0 hi, I0 lo, Q0 hi, Q0 lo across the four lanes
        img[63:56] = (lane[0]) ? s[lane/2][7:0] : s[lane/2][15:8];
      end
      lfam_pkg::LFAM_FMT_C8422: begin
        // lanes carry I0, I1, Q0, Q1
        img[63:48] = s[(lane % 2) * 2 + lane / 2];
      end
      lfam_pkg::LFAM_FMT_C4421N: begin
        if (lane < 2) begin
          img[63:48] = s[lane];
        end
      end
      lfam_pkg::LFAM_FMT_C4421W: begin
        if (lane == 1 || lane == 2) begin
          img[63:48] = s[lane-1];
        end
      end
      lfam_pkg::LFAM_FMT_C4442: begin
        if (lane == 1 || lane == 2) begin
          img[63:32] = {s[lane-1], s[lane+1]};
        end
      end
      lfam_pkg::LFAM_FMT_C2441: begin
        if (lane == 1) begin
          img[63:32] = {s[0], s[1]};
        end
      end
      default: img = '0;
    endcase
    return img;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // frame fifo in the sample path
  lfam_fifo #(
    .WIDTH($bits(lfam_pkg::lfam_frame_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_frame),
    .out_valid(head_valid),
    .out_ready(pop),
    .out_data(head)
  );

  // decode of the live configuration, shared by status and sequencer
  always_comb begin
    fmt = decode(st.cfg);
    f_len = frame_octets(fmt);
    m_cnt = (fmt == lfam_pkg::LFAM_FMT_NONE) ? 4'h0 :
            (fmt == lfam_pkg::LFAM_FMT_B14 ||
             fmt == lfam_pkg::LFAM_FMT_B12) ? 4'h2 : 4'h4;
    l_cnt = 4'($countones({lane_mask(fmt), lane_mask(fmt)}));
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state: registers, link state and frame sequencer
  always_comb begin
    next_st = st;
    pop = 1'b0;
    next_st.start = 1'b0;
    next_st.rdata = '0;

    // register writes; config is frozen while the link is up
    if (reg_wr && reg_addr == lfam_pkg::REG_CONFIG) begin
      if (!st.up) begin
        next_st.cfg = reg_wdata[13:0];
      end else begin
        next_st.reject = 1'b1;
      end
    end else if (reg_wr && reg_addr == lfam_pkg::REG_STATUS &&
                 reg_wdata[lfam_pkg::ST_REJECT]) begin
      next_st.reject = 1'b0;
    end

    // register reads, data valid the following cycle only
    if (reg_rd) begin
      case (reg_addr)
        lfam_pkg::REG_CONFIG: next_st.rdata = {18'h0, st.cfg};
        lfam_pkg::REG_STATUS: begin
          next_st.rdata[lfam_pkg::ST_LINK_UP] = st.up;
          next_st.rdata[lfam_pkg::ST_LEGAL] =
            (fmt != lfam_pkg::LFAM_FMT_NONE);
          next_st.rdata[lfam_pkg::ST_REJECT] = st.reject;
          next_st.rdata[lfam_pkg::ST_F_LSB +: 4] = f_len;
          next_st.rdata[lfam_pkg::ST_M_LSB +: 4] = m_cnt;
          next_st.rdata[lfam_pkg::ST_L_LSB +: 4] = l_cnt;
        end
        lfam_pkg::REG_FRAMES: next_st.rdata = st.frames;
        lfam_pkg::REG_UNDERRUNS: next_st.rdata = st.underruns;
        default: next_st.rdata = '0;
      endcase
    end

    // link comes up only when the receiver releases sync on a legal format
    next_st.up = sync_n && (fmt != lfam_pkg::LFAM_FMT_NONE);

    if (!st.up) begin
      // a dropped link abandons the frame in flight
      next_st.sending = 1'b0;
      next_st.octet = '0;
      next_st.a_sh = '0;
      next_st.b_sh = '0;
      next_st.lane_en = '0;
    end else if (!st.sending || {1'b0, st.octet} == f_len - 4'h1) begin
      // frame boundary: restart the mapping from the next fifo entry
      next_st.sending = 1'b1;
      next_st.octet = '0;
      next_st.start = 1'b1;
      next_st.frames = st.frames + 32'h1;
      next_st.lane_en = {lane_mask(fmt), lane_mask(fmt)};
      pop = head_valid;
      for (int k = 0; k < 4; k++) begin
        // an empty fifo sends a zero frame to keep framing intact
        next_st.a_sh[k] = head_valid ? build_lane(fmt, head.chan_a, k) : '0;
        next_st.b_sh[k] = head_valid ? build_lane(fmt, head.chan_b, k) : '0;
      end
      if (!head_valid) begin
        next_st.underruns = st.underruns + 32'h1;
      end
    end else begin
      // next column: shift every lane by one octet
      next_st.octet = st.octet + 3'h1;
      for (int k = 0; k < 4; k++) begin
        next_st.a_sh[k] = {st.a_sh[k][55:0], 8'h00};
        next_st.b_sh[k] = {st.b_sh[k][55:0], 8'h00};
      end
    end
  end

  // registered state
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st <= '0;
      st.cfg <= lfam_pkg::CFG_RESET;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from state flops
  assign reg_rdata = st.rdata;
  assign lanes.chan_a_lane_zero = st.a_sh[0][63:56];
  assign lanes.chan_a_lane_one = st.a_sh[1][63:56];
  assign lanes.chan_a_lane_two = st.a_sh[2][63:56];
  assign lanes.chan_a_lane_three = st.a_sh[3][63:56];
  assign lanes.chan_b_lane_zero = st.b_sh[0][63:56];
  assign lanes.chan_b_lane_one = st.b_sh[1][63:56];
  assign lanes.chan_b_lane_two = st.b_sh[2][63:56];
  assign lanes.chan_b_lane_three = st.b_sh[3][63:56];
  assign lane_enable = st.lane_en;
  assign frame_start = st.start;
  assign link_up = st.up;

endmodule

// *** src/lfam_pkg.sv ***
// Purpose: shared constants and types for the lane frame assembly mapper
// Assumes: one register word per address, 32-bit register data
// Notes: lane octet images are 64 bits, first octet in bits 63:56
package lfam_pkg;

  // register byte offsets
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FRAMES = 8'h08;
  localparam logic [7:0] REG_UNDERRUNS = 8'h0c;

  // config field positions
  localparam int CFG_CODE_FIRST_LSB = 0;
  localparam int CFG_CODE_SECOND_LSB = 2;
  localparam int CFG_CODE_THIRD_LSB = 4;
  localparam int CFG_MULT_LSB = 6;
  localparam int CFG_DECIM_LSB = 8;
  localparam logic [13:0] CFG_RESET = 14'h0000;

  // status field positions
  localparam int ST_LINK_UP = 0;
  localparam int ST_LEGAL = 1;
  localparam int ST_REJECT = 2;
  localparam int ST_F_LSB = 4;
  localparam int ST_M_LSB = 8;
  localparam int ST_L_LSB = 12;

  // serial multiplier field encodings
  localparam logic [1:0] MULT_16X = 2'h0;
  localparam logic [1:0] MULT_20X = 2'h1;
  localparam logic [1:0] MULT_40X = 2'h2;

  // decimation field value that selects bypass
  localparam logic [5:0] DECIM_BYPASS = 6'h01;

  localparam int SAMPLES = 20;
  localparam int FIFO_DEPTH = 4;

  typedef enum {
    LFAM_FMT_NONE, LFAM_FMT_B14, LFAM_FMT_B12, LFAM_FMT_C8411,
    LFAM_FMT_C8422, LFAM_FMT_C4421W, LFAM_FMT_C4421N, LFAM_FMT_C4442,
    LFAM_FMT_C2441
  } lfam_fmt_t;

  // one frame of samples per channel; complex order is I0,Q0,I1,Q1
  typedef struct packed {
    logic [SAMPLES-1:0][15:0] chan_b;
    logic [SAMPLES-1:0][15:0] chan_a;
  } lfam_frame_t;

  typedef struct packed {
    logic [7:0] chan_b_lane_three;
    logic [7:0] chan_b_lane_two;
    logic [7:0] chan_b_lane_one;
    logic [7:0] chan_b_lane_zero;
    logic [7:0] chan_a_lane_three;
    logic [7:0] chan_a_lane_two;
    logic [7:0] chan_a_lane_one;
    logic [7:0] chan_a_lane_zero;
  } lfam_lanes_t;

endpackage

// *** test/lfam_mapper_props.sv ***
// Purpose: port assertions for the lane frame assembly mapper
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to every lfam_mapper instance
`timescale 1ns/1ps
////////////////////////////////////////
module lfam_props (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic in_ready,
  input wire logic sync_n,
  input wire lfam_pkg::lfam_lanes_t lanes,
  input wire logic [7:0] lane_enable,
  input wire logic frame_start,
  input wire logic link_up
);
  logic [63:0] off_mask;
  // octet positions of lanes that are switched off
  always_comb begin
    for (int j = 0; j < 8; j++) begin
      off_mask[j*8 +: 8] = {8{~lane_enable[j]}};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  a_link_drop: assert property (!sync_n |=> !link_up)
    else $error("link stayed up after sync request");
  a_link_cause: assert property (link_up |-> $past(sync_n))
    else $error("link up without sync high");
  a_lanes_quiet: assert property (!link_up ##1 !link_up |->
    lanes == '0 && lane_enable == 8'h0 && !frame_start)
    else $error("lanes active while link down");
  a_first_frame: assert property ($rose(link_up) |=> frame_start)
    else $error("no frame start after link up");
  // start is launched from the link state one cycle earlier, so a sync drop
  // may land in the same cycle as a frame boundary
  a_start_up: assert property (frame_start |-> $past(link_up))
    else $error("frame start while link down");
  a_lane_gate: assert property ((lanes & off_mask) == 64'h0)
    else $error("data on a disabled lane");
  a_enable_hold: assert property (link_up && $past(link_up) &&
    !frame_start |-> $stable(lane_enable))
    else $error("lane enable changed mid frame");
  a_cfg_echo: assert property (reg_wr && reg_addr ==
    lfam_pkg::REG_CONFIG && !link_up ##1 reg_rd && reg_addr ==
    lfam_pkg::REG_CONFIG |=> reg_rdata[13:0] == $past(reg_wdata[13:0], 2))
    else $error("config readback differs from write");
  a_reject_set: assert property (reg_wr && reg_addr ==
    lfam_pkg::REG_CONFIG && link_up ##1 reg_rd && reg_addr ==
    lfam_pkg::REG_STATUS |=> reg_rdata[lfam_pkg::ST_REJECT])
    else $error("refused config write not flagged");
  c_link: cover property ($rose(link_up));
  c_full: cover property ($fell(in_ready));
  c_reject: cover property (reg_wr && link_up);
endmodule

bind lfam_mapper lfam_props i_lfam_props (.sys_clk(sys_clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .in_ready(in_ready), .sync_n(sync_n), .lanes(lanes),
  .lane_enable(lane_enable), .frame_start(frame_start), .link_up(link_up));

// *** test/lfam_mapper_tb_top.sv ***
// Purpose: self-checking bench for the lane frame assembly mapper
// Assumes: 100 MHz sys_clk, receiver model on the lanes
// Notes: expected frames queue up, a watcher pops them per frame
`timescale 1ns/1ps
////////////////////////////////////////
module lfam_mapper_tb_top;
  logic sys_clk, reset_n, reg_wr, reg_rd, in_valid, in_ready;
  logic want_link, sync_n, done, frame_start, link_up;
  logic [7:0] reg_addr, lane_enable;
  logic [31:0] reg_wdata, reg_rdata, seed;
  logic [63:0] v;
  logic [3:0] f_oct;
  logic [7:0][63:0] img, we;
  logic [7:0][63:0] exp_q[$];
  lfam_pkg::lfam_frame_t in_frame;
  lfam_pkg::lfam_lanes_t lanes;
  int bad_count, n_tests;
  // {status expected, config}; zero status marks an illegal set
  localparam logic [31:0] TBL[20] = '{32'h8412_0445, 32'h8422_0441,
    32'h4422_0490, 32'h4442_0482, 32'h8412_0645, 32'h8422_0641,
    32'h4422_0690, 32'h4442_0682, 32'h4422_0841, 32'h2442_0882,
    32'h4422_0941, 32'h2442_0a82, 32'h4422_0c41, 32'h4422_1041,
    32'h2442_1282, 32'h2442_1482, 32'h2442_1881, 32'h2442_2082,
    32'h0000_1882, 32'h0000_0485};

  lfam_mapper i_lfam_mapper (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
    .in_ready(in_ready), .in_frame(in_frame), .sync_n(sync_n),
    .lanes(lanes), .lane_enable(lane_enable), .frame_start(frame_start),
    .link_up(link_up));
  lfam_rx_model i_lfam_rx_model (.sys_clk(sys_clk), .reset_n(reset_n),
    .want_link(want_link), .f_oct(f_oct), .lanes(lanes),
    .frame_start(frame_start), .link_up(link_up), .sync_n(sync_n),
    .done(done), .img(img));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // one bus cycle; strobes stay until the next call
  task automatic bus(input logic w, r, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, 1'b1, a, 32'h0);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    #1 v = 64'(reg_rdata);
  endtask

  // lane images of one channel: 0 = 14-bit, 1 = 12-bit, 2 = complex 8422
  function automatic logic [3:0][63:0] cimg(int m, logic [19:0][15:0] s);
    logic [3:0][63:0] r;
    r = '0;
    for (int k = 0; k < 4; k++) begin
      if (m == 0) r[k] = {s[k][13:6], s[k][5:0], 2'b00, 48'h0};
      else if (m == 2) r[k] = {s[{k[0], k[1]}], 48'h0};
      else for (int i = 0; i < 5; i++) r[k][63-12*i -: 12] = s[5*k+i][13:2];
    end
    return r;
  endfunction

  // fill the fifo while down, bring the link up, then try a refused write
  task automatic run(int m, logic [31:0] cfg, logic [63:0] st,
      logic [3:0] f);
    lfam_pkg::lfam_frame_t fr;
    logic [31:0] rv;
    f_oct <= f;
    bus(1'b1, 1'b0, lfam_pkg::REG_CONFIG, cfg);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    for (int i = 0; i < 4; i++) begin
      for (int w = 0; w < 40; w++) begin
        rv = rnd();
        fr[w*16 +: 16] = rv[15:0] & (m == 2 ? 16'hffff : 16'h3fff);
      end
      exp_q.push_back({cimg(m, fr.chan_b), cimg(m, fr.chan_a)});
      @(posedge sys_clk);
      in_valid <= 1'b1;
      in_frame <= fr;
    end
    @(posedge sys_clk);
    in_valid <= 1'b0;
    exp_q.push_back('0);
    repeat (2) @(posedge sys_clk);
    chk(64'(in_ready), 64'h0);
    want_link <= 1'b1;
    for (int t = 0; t < 300 && exp_q.size() > 0; t++) @(posedge sys_clk);
    chk(64'(exp_q.size()), 64'h0);
    chk(64'(lane_enable), 64'hff);
    bus(1'b1, 1'b0, lfam_pkg::REG_CONFIG, 32'h0);
    rd(lfam_pkg::REG_STATUS);
    chk(v, st);
    rd(lfam_pkg::REG_CONFIG);
    chk(v, 64'(cfg));
    bus(1'b1, 1'b0, lfam_pkg::REG_STATUS, 32'h4);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    want_link <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  // compare each received frame with the oldest expectation
  always @(posedge sys_clk) begin
    if (done && exp_q.size() > 0) begin
      we = exp_q.pop_front();
      for (int j = 0; j < 8; j++) chk(img[j], we[j]);
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    results();
  end

  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    in_valid = 1'b0;
    in_frame = '0;
    want_link = 1'b0;
    f_oct = 4'h2;
    seed = 32'ha32ed92e;
    bad_count = 0;
    n_tests = 0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1 chk(64'(in_ready), 64'h1);
    rd(lfam_pkg::REG_STATUS);
    chk(v, 64'h0);
    bus(1'b1, 1'b0, 8'h10, 32'hffff);
    rd(8'h10);
    chk(v, 64'h0);
    rd(lfam_pkg::REG_CONFIG);
    chk(v, 64'(lfam_pkg::CFG_RESET));
    run(0, 32'h141, 64'h8227, 4'h2);
    run(1, 32'h103, 64'h8287, 4'h8);
    run(2, 32'h441, 64'h8427, 4'h2);
    // every tabulated format, plus two the device must not accept
    foreach (TBL[i]) begin
      bus(1'b1, 1'b0, lfam_pkg::REG_CONFIG, {16'h0, TBL[i][15:0]});
      rd(lfam_pkg::REG_CONFIG);
      chk(v, 64'(TBL[i][15:0]));
      rd(lfam_pkg::REG_STATUS);
      chk(v & (TBL[i][31:16] != 16'h0 ? 64'hffff : 64'h2), 64'(TBL[i][31:16]));
    end
    results();
  end
endmodule

// *** test/lfam_rx_model.sv ***
// Purpose: serial link receiver standing at the far side of the lanes
// Assumes: the bench tells it F octets per frame
// Notes: raw octets only, no comma or alignment handling
`timescale 1ns/1ps
////////////////////////////////////////
module lfam_rx_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic want_link,
  input wire logic [3:0] f_oct,
  input wire lfam_pkg::lfam_lanes_t lanes,
  input wire logic frame_start,
  input wire logic link_up,
  output logic sync_n,
  output logic done,
  output logic [7:0][63:0] img
);
  logic [7:0][63:0] acc;
  logic [3:0] n;
  // sync drops before any format change, rises again afterwards
  always @(posedge sys_clk) sync_n <= reset_n && want_link;
  // gather one frame per lane, first octet at the top of the image
  always @(posedge sys_clk) begin
    logic [3:0] k;
    logic [63:0] lv;
    k = frame_start ? 4'h0 : n;
    lv = lanes;
    done <= 1'b0;
    if (!reset_n || !link_up) begin
      n <= 4'h0;
    end else if (frame_start || n != 4'h0) begin
      for (int j = 0; j < 8; j++) begin
        if (k == 4'h0) acc[j] = 64'h0;
        acc[j][63-8*k -: 8] = lv[j*8 +: 8];
      end
      if (k + 4'h1 == f_oct) begin
        img <= acc;
        done <= 1'b1;
        n <= 4'h0;
      end else begin
        n <= k + 4'h1;
      end
    end
  end
endmodule
